/* pkg/amux_pkg.sv */
// constants shared by both ends of the split address multiplexed port
package amux_pkg;
  // ****************************************
  // bus widths
  // ****************************************
  localparam int DQ_W   = 16;
  localparam int UP_W   = 10;
  localparam int ADDR_W = DQ_W + UP_W;
  localparam int WB_AW  = 8;
  localparam int WB_DW  = 32;
  localparam int LAT_W  = 4;

  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_NS    = 50;
  localparam int ACCESS_NS = 96;
  localparam int SENSE_W   = 2;
  localparam int SENSE_INT = ACCESS_NS / CLK_NS;
  localparam logic [SENSE_W-1:0] SENSE_CYC =
    SENSE_W'((SENSE_INT < 1) ? 1 : SENSE_INT);
  localparam int WL_BITS   = 4;
  localparam int EOW_W     = 2;
  localparam logic [EOW_W-1:0] EOW_STALL = 2'h2;
  localparam int DIV_W     = 3;
  localparam logic [DIV_W-1:0] DIV_LAST = 3'h3;
  localparam int TMR_W     = 4;
  localparam logic [TMR_W-1:0] STEP_CYC = 4'h1;
  localparam logic [TMR_W-1:0] OE_WAIT_CYC = 4'h8;

  // ****************************************
  // controller registers
  // ****************************************
  localparam logic [WB_AW-1:0] REG_CTRL  = 8'h00;
  localparam logic [WB_AW-1:0] REG_ADDR  = 8'h04;
  localparam logic [WB_AW-1:0] REG_WDATA = 8'h08;
  localparam logic [WB_AW-1:0] REG_RDATA = 8'h0C;
  localparam logic [WB_AW-1:0] REG_STAT  = 8'h10;
  localparam int CTRL_W     = 16;
  localparam int CTRL_GO    = 0;
  localparam int CTRL_OP    = 1;
  localparam int OP_W       = 2;
  localparam int CTRL_TWO   = 3;
  localparam int CTRL_KEEP  = 4;
  localparam int CTRL_POL   = 5;
  localparam int CTRL_EARLY = 6;
  localparam int CTRL_LEN   = 8;
  localparam int LEN_W      = 8;
  localparam logic [OP_W-1:0] OP_ARD = 2'h0;
  localparam logic [OP_W-1:0] OP_AWR = 2'h1;
  localparam logic [OP_W-1:0] OP_SRD = 2'h2;
  localparam int STAT_BUSY  = 0;
  localparam int STAT_DONE  = 1;
  localparam int STAT_CNT   = 8;
endpackage

/* pkg/amux_link_if.sv */
// pins between the host controller and the device port
`timescale 1ns/1ps
`default_nettype none
interface amux_link_if;
  logic                      lclk;
  logic                      ce_n;
  logic                      oe_n;
  logic                      we_n;
  logic                      addr_valid_strobe_n;
  logic [amux_pkg::DQ_W-1:0] host_dq;
  logic                      host_dq_oe;
  logic [amux_pkg::DQ_W-1:0] dev_dq;
  logic                      dev_dq_oe;
  logic                      stall_pin;
  logic                      stall_oe;
  logic [amux_pkg::DQ_W-1:0] dq;
  logic                      stall_line;

  // undriven lines float high
  assign dq = dev_dq_oe ? dev_dq : (host_dq_oe ? host_dq : '1);
  assign stall_line = stall_oe ? stall_pin : 1'h1;

  modport host (
    output lclk, ce_n, oe_n, we_n, addr_valid_strobe_n,
    output host_dq, host_dq_oe,
    input  dq, stall_line
  );
  modport dev (
    input  lclk, ce_n, oe_n, we_n, addr_valid_strobe_n, dq,
    output dev_dq, dev_dq_oe, stall_pin, stall_oe
  );
endinterface
`default_nettype wire

/* rtl/amux_dev.sv */
// device end of the split address multiplexed bus port
`timescale 1ns/1ps
`default_nettype none
// How it works
// - entering split mode clears stored upper address
// - stall pin driven exactly when data driven
// - sync stall shows ready after latency; async always
// - host pulses strobe once or twice per cycle
// - output enable low upper, high lower address
// - skipped upper phase reuses last upper address
// - lower address capture starts array sensing
// - async access counted from strobe rising edge
// - a new lower address restarts an unfinished read, any number of times
// - sync upper first, lower second, else stored
// - sync addresses latched on link clock rise
// - held strobe gives upper, lower on consecutive clocks
// - host lowers output enable after address hold
// - host output enable timed like strobe
// - write completes on write enable rise
// - stall polarity and timing follow configuration
// - word line crossing inserts signalled stall states
// - host may keep chip enable low between cycles
// - boot from low region, enable mode after
module amux_dev (
  // clock and reset
  input  wire logic                         clk_i,
  input  wire logic                         rst_i,
  // pins
  amux_link_if.dev                          lnk,
  // configuration
  input  wire logic                         mode_en_i,
  input  wire logic                         async_mode_i,
  input  wire logic                         stall_pol_i,
  input  wire logic                         stall_early_i,
  input  wire logic [amux_pkg::LAT_W-1:0]   latency_i,
  // array side
  output logic      [amux_pkg::ADDR_W-1:0]  arr_addr_o,
  output logic                              arr_rd_o,
  input  wire logic [amux_pkg::DQ_W-1:0]    arr_data_i,
  output logic                              wr_o,
  output logic      [amux_pkg::ADDR_W-1:0]  wr_addr_o,
  output logic      [amux_pkg::DQ_W-1:0]    wr_data_o,
  output logic                              split_mode_o
);

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    logic [2:0]                       lclk;
    logic [2:0]                       avs;
    logic [2:0]                       oe;
    logic [2:0]                       we;
    logic [2:0]                       ce;
    logic [2:0][amux_pkg::DQ_W-1:0]   dq;
    logic                             mode;
    logic [amux_pkg::UP_W-1:0]        upper;
    logic [amux_pkg::DQ_W-1:0]        lower;
    logic                             have;
    logic                             burst;
    logic [amux_pkg::SENSE_W-1:0]     sense;
    logic [amux_pkg::LAT_W-1:0]       lat;
    logic [amux_pkg::EOW_W-1:0]       eow;
    logic                             valid;
    logic [amux_pkg::DQ_W-1:0]        dout;
    logic                             dout_oe;
    logic                             stall_pin;
    logic                             arr_rd;
    logic                             wr;
    logic [amux_pkg::ADDR_W-1:0]      wr_addr;
    logic [amux_pkg::DQ_W-1:0]        wr_data;
  } dev_state_t;

  localparam dev_state_t RST_STATE = '{
    avs:     '1,
    oe:      '1,
    we:      '1,
    ce:      '1,
    default: '0
  };

  dev_state_t s;
  dev_state_t n;
  logic       lrise;
  logic       vrise;
  logic       vfall;
  logic       wrise;
  logic       sel;
  logic       split;
  logic       rdy;

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    n = s;
    // stage 0 feeds stage 1 only; logic looks at stages 1 and 2
    n.lclk = {s.lclk[1:0], lnk.lclk};
    n.avs  = {s.avs[1:0], lnk.addr_valid_strobe_n};
    n.oe   = {s.oe[1:0], lnk.oe_n};
    n.we   = {s.we[1:0], lnk.we_n};
    n.ce   = {s.ce[1:0], lnk.ce_n};
    n.dq   = {s.dq[1:0], lnk.dq};
    lrise  = s.lclk[1] & ~s.lclk[2];
    vrise  = s.avs[1] & ~s.avs[2];
    vfall  = ~s.avs[1] & s.avs[2];
    wrise  = s.we[1] & ~s.we[2];
    sel    = ~s.ce[1];
    split  = mode_en_i & s.mode;
    n.arr_rd = 1'h0;
    n.wr     = 1'h0;
    n.mode   = mode_en_i;

    // upper lines read as grounded outside split mode
    if (!split) begin
      n.upper = '0;
    end

    // a deselect or a new strobe ends the data phase
    if (!sel || vfall) begin
      n.have  = 1'h0;
      n.burst = 1'h0;
      n.valid = 1'h0;
    end

    // asynchronous sensing
    if (s.sense != '0) begin
      n.sense = s.sense - 1'h1;
      if (n.sense == '0) begin
        n.dout  = arr_data_i;
        n.valid = 1'h1;
      end
    end

    // burst advance on each link clock rise
    if (s.burst && lrise) begin
      if (s.lat != '0) begin
        n.lat   = s.lat - 1'h1;
        n.valid = 1'h0;
      end else if (s.eow != '0) begin
        n.eow   = s.eow - 1'h1;
        n.valid = 1'h0;
      end else begin
        n.dout  = arr_data_i;
        n.valid = 1'h1;
        n.lower = s.lower + 1'h1;
        if (n.lower[amux_pkg::WL_BITS-1:0] == '0) begin
          n.eow = amux_pkg::EOW_STALL;
        end
      end
    end

    // address capture; a restart reloads sensing
    if (sel && async_mode_i && vrise) begin
      if (split && !s.oe[2]) begin
        n.upper = s.dq[2][amux_pkg::UP_W-1:0];
      end else begin
        n.lower  = s.dq[2];
        n.have   = 1'h1;
        n.burst  = 1'h0;
        n.valid  = 1'h0;
        n.sense  = amux_pkg::SENSE_CYC;
        n.arr_rd = 1'h1;
      end
    end else if (sel && !async_mode_i && lrise && !s.avs[1]) begin
      if (split && !s.oe[1]) begin
        n.upper = s.dq[1][amux_pkg::UP_W-1:0];
      end else begin
        n.lower  = s.dq[1];
        n.have   = 1'h1;
        n.burst  = 1'h1;
        n.valid  = 1'h0;
        n.lat    = latency_i;
        n.eow    = '0;
        n.arr_rd = 1'h1;
      end
    end

    // writes complete on the write enable rise, clock or not
    if (sel && wrise) begin
      n.wr      = 1'h1;
      n.wr_addr = {s.upper, s.lower};
      n.wr_data = s.dq[2];
    end

    // drivers only after the lower address and with oe low
    n.dout_oe = sel & ~s.oe[1] & s.we[1] & n.have;

    // ready level, then polarity
    if (async_mode_i) begin
      rdy = 1'h1;
    end else if (stall_early_i) begin
      rdy = n.burst & (n.lat == '0) & (n.eow == '0);
    end else begin
      rdy = n.valid;
    end
    n.stall_pin = stall_pol_i ? ~rdy : rdy;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s <= RST_STATE;
    end else begin
      s <= n;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign lnk.dev_dq    = s.dout;
  assign lnk.dev_dq_oe = s.dout_oe;
  assign lnk.stall_pin = s.stall_pin;
  assign lnk.stall_oe  = s.dout_oe;
  assign arr_addr_o    = {s.upper, s.lower};
  assign arr_rd_o      = s.arr_rd;
  assign wr_o          = s.wr;
  assign wr_addr_o     = s.wr_addr;
  assign wr_data_o     = s.wr_data;
  assign split_mode_o  = s.mode;

endmodule
`default_nettype wire

/* rtl/amux_host.sv */
// host controller end of the split address multiplexed bus port
`timescale 1ns/1ps
`default_nettype none
module amux_host (
  // clock and reset
  input  wire logic                         clk_i,
  input  wire logic                         rst_i,
  // wishbone slave
  input  wire logic                         wb_cyc_i,
  input  wire logic                         wb_stb_i,
  input  wire logic                         wb_we_i,
  input  wire logic [amux_pkg::WB_AW-1:0]   wb_adr_i,
  input  wire logic [amux_pkg::WB_DW-1:0]   wb_dat_i,
  input  wire logic [3:0]                   wb_sel_i,
  output logic      [amux_pkg::WB_DW-1:0]   wb_dat_o,
  output logic                              wb_ack_o,
  // pins
  amux_link_if.host                         lnk
);

  // ****************************************
  // state
  // ****************************************
  typedef enum logic [3:0] {
    ST_IDLE, ST_UP_LO, ST_UP_HI, ST_LO_LO, ST_LO_HI, ST_REL,
    ST_OE_RD, ST_WE_LO, ST_WE_HI, ST_SADR, ST_SDAT, ST_FIN
  } st_t;
  typedef enum logic [2:0] {
    SP_START, SP_UP, SP_GAP, SP_LO, SP_REL
  } sph_t;
  typedef struct packed {
    st_t                               st;
    sph_t                              sph;
    logic [amux_pkg::TMR_W-1:0]        tmr;
    logic [amux_pkg::DIV_W-1:0]        div;
    logic                              lclk;
    logic                              ce_n;
    logic                              oe_n;
    logic                              we_n;
    logic                              avs_n;
    logic [amux_pkg::DQ_W-1:0]         dq;
    logic                              dq_oe;
    logic [1:0][amux_pkg::DQ_W-1:0]    dq_s;
    logic [1:0]                        stl_s;
    logic                              armed;
    logic                              rdy_prev;
    logic                              start;
    logic [amux_pkg::CTRL_W-1:0]       ctrl;
    logic [amux_pkg::ADDR_W-1:0]       addr;
    logic [amux_pkg::DQ_W-1:0]         wdata;
    logic [amux_pkg::DQ_W-1:0]         rdata;
    logic [amux_pkg::LEN_W-1:0]        cnt;
    logic                              busy;
    logic                              done;
    logic                              ack;
    logic [amux_pkg::WB_DW-1:0]        dat;
  } host_state_t;

  localparam host_state_t RST_STATE = '{
    st: ST_IDLE, sph: SP_START, ce_n: 1'h1, oe_n: 1'h1,
    we_n: 1'h1, avs_n: 1'h1, default: '0
  };

  host_state_t                  s;
  host_state_t                  n;
  logic [amux_pkg::WB_DW-1:0]   wmask;
  logic [amux_pkg::WB_DW-1:0]   rd;
  logic [amux_pkg::WB_DW-1:0]   wd;
  logic [amux_pkg::DQ_W-1:0]    up16;
  logic [amux_pkg::OP_W-1:0]    op;
  logic                         req;
  logic                         edge_now;
  logic                         lfall;
  logic                         lrise;
  logic                         adv;
  logic                         rdy;
  logic                         take;

  for (genvar b = 0; b < 4; b++) begin : g_lane
    assign wmask[8*b +: 8] = {8{wb_sel_i[b]}};
  end

  always_comb begin
    n = s;
    n.start  = 1'h0;
    n.dq_s   = {s.dq_s[0], lnk.dq};
    n.stl_s  = {s.stl_s[0], lnk.stall_line};
    op       = s.ctrl[amux_pkg::CTRL_OP +: amux_pkg::OP_W];
    up16     = amux_pkg::DQ_W'(s.addr[amux_pkg::ADDR_W-1:amux_pkg::DQ_W]);
    rdy      = s.stl_s[1] ^ s.ctrl[amux_pkg::CTRL_POL];
    take     = 1'h0;
    // link clock divider, free running
    edge_now = (s.div == amux_pkg::DIV_LAST);
    n.div    = edge_now ? '0 : s.div + 1'h1;
    n.lclk   = edge_now ? ~s.lclk : s.lclk;
    lfall    = edge_now & s.lclk;
    lrise    = edge_now & ~s.lclk;
    adv      = (s.tmr == '0);
    if (!adv) begin
      n.tmr = s.tmr - 1'h1;
    end

    // ****************************************
    // register slave
    // ****************************************
    req   = wb_cyc_i & wb_stb_i & ~s.ack;
    n.ack = req;
    case (wb_adr_i)
      amux_pkg::REG_CTRL:  rd = 32'(s.ctrl);
      amux_pkg::REG_ADDR:  rd = 32'(s.addr);
      amux_pkg::REG_WDATA: rd = 32'(s.wdata);
      amux_pkg::REG_RDATA: rd = 32'(s.rdata);
      amux_pkg::REG_STAT:  rd = 32'({s.cnt, 6'h00, s.done, s.busy});
      default:             rd = '0;
    endcase
    wd = (wb_dat_i & wmask) | (rd & ~wmask);
    if (req) begin
      n.dat = wb_we_i ? '0 : rd;
    end
    if (req && wb_we_i) begin
      case (wb_adr_i)
        amux_pkg::REG_CTRL: if (!s.busy) begin
          n.ctrl = wd[amux_pkg::CTRL_W-1:0];
          n.ctrl[amux_pkg::CTRL_GO] = 1'h0;
          n.start = wd[amux_pkg::CTRL_GO];
        end
        amux_pkg::REG_ADDR: if (!s.busy) begin
          n.addr = wd[amux_pkg::ADDR_W-1:0];
        end
        amux_pkg::REG_WDATA: if (!s.busy) begin
          n.wdata = wd[amux_pkg::DQ_W-1:0];
        end
        amux_pkg::REG_STAT: begin
          if (wb_sel_i[0] && wb_dat_i[amux_pkg::STAT_DONE]) begin
            n.done = 1'h0;
          end
        end
        default: begin
        end
      endcase
    end

    // ****************************************
    // bus cycle sequencer
    // ****************************************
    unique case (s.st)
      ST_IDLE: if (s.start) begin
        n.busy = 1'h1;
        n.cnt  = '0;
        n.tmr  = amux_pkg::STEP_CYC;
        if (op == amux_pkg::OP_SRD) begin
          n.st  = ST_SADR;
          n.sph = SP_START;
        end else begin
          n.ce_n  = 1'h0;
          n.avs_n = 1'h0;
          n.dq_oe = 1'h1;
          n.oe_n  = ~s.ctrl[amux_pkg::CTRL_TWO];
          n.dq    = s.ctrl[amux_pkg::CTRL_TWO] ? up16 : s.addr[15:0];
          n.st    = s.ctrl[amux_pkg::CTRL_TWO] ? ST_UP_LO : ST_LO_LO;
        end
      end
      ST_UP_LO: if (adv) begin
        n.avs_n = 1'h1;
        n.tmr   = amux_pkg::STEP_CYC;
        n.st    = ST_UP_HI;
      end
      ST_UP_HI: if (adv) begin
        n.oe_n  = 1'h1;
        n.avs_n = 1'h0;
        n.dq    = s.addr[15:0];
        n.tmr   = amux_pkg::STEP_CYC;
        n.st    = ST_LO_LO;
      end
      ST_LO_LO: if (adv) begin
        n.avs_n = 1'h1;
        n.tmr   = amux_pkg::STEP_CYC;
        n.st    = ST_LO_HI;
      end
      ST_LO_HI: if (adv) begin
        n.tmr = amux_pkg::STEP_CYC;
        if (op == amux_pkg::OP_AWR) begin
          n.dq   = s.wdata;
          n.we_n = 1'h0;
          n.st   = ST_WE_LO;
        end else begin
          n.dq_oe = 1'h0;
          n.st    = ST_REL;
        end
      end
      ST_REL: if (adv) begin
        n.oe_n = 1'h0;
        n.tmr  = amux_pkg::OE_WAIT_CYC;
        n.st   = ST_OE_RD;
      end
      ST_OE_RD: if (adv) begin
        n.rdata = s.dq_s[1];
        n.cnt   = s.cnt + 1'h1;
        n.st    = ST_FIN;
      end
      ST_WE_LO: if (adv) begin
        n.we_n = 1'h1;
        n.tmr  = amux_pkg::STEP_CYC;
        n.st   = ST_WE_HI;
      end
      ST_WE_HI: if (adv) begin
        n.cnt = s.cnt + 1'h1;
        n.st  = ST_FIN;
      end
      ST_SADR: if (lfall) begin
        unique case (s.sph)
          SP_START: begin
            n.ce_n  = 1'h0;
            n.avs_n = 1'h0;
            n.dq_oe = 1'h1;
            n.oe_n  = ~s.ctrl[amux_pkg::CTRL_TWO];
            n.dq    = s.ctrl[amux_pkg::CTRL_TWO] ? up16 : s.addr[15:0];
            n.sph   = s.ctrl[amux_pkg::CTRL_TWO] ? SP_UP : SP_LO;
          end
          SP_UP: begin
            n.oe_n  = 1'h1;
            n.dq    = s.addr[15:0];
            n.avs_n = ~s.ctrl[amux_pkg::CTRL_KEEP];
            n.sph   = s.ctrl[amux_pkg::CTRL_KEEP] ? SP_LO : SP_GAP;
          end
          SP_GAP: begin
            n.avs_n = 1'h0;
            n.sph   = SP_LO;
          end
          SP_LO: begin
            n.avs_n = 1'h1;
            n.dq_oe = 1'h0;
            n.sph   = SP_REL;
          end
          SP_REL: begin
            n.oe_n  = 1'h0;
            n.armed = 1'h0;
            n.st    = ST_SDAT;
          end
        endcase
      end
      ST_SDAT: if (lrise) begin
        n.armed    = 1'h1;
        // the first rise may see the stall line still undriven
        n.rdy_prev = s.armed & rdy;
        take = s.armed & (s.ctrl[amux_pkg::CTRL_EARLY] ? s.rdy_prev : rdy);
        if (take) begin
          n.rdata = s.dq_s[1];
          n.cnt   = s.cnt + 1'h1;
          if (n.cnt == s.ctrl[amux_pkg::CTRL_LEN +: amux_pkg::LEN_W]) begin
            n.tmr = amux_pkg::STEP_CYC;
            n.st  = ST_FIN;
          end
        end
      end
      ST_FIN: begin
        n.ce_n  = 1'h1;
        n.oe_n  = 1'h1;
        n.we_n  = 1'h1;
        n.avs_n = 1'h1;
        n.dq_oe = 1'h0;
        if (adv) begin
          n.busy = 1'h0;
          n.done = 1'h1;
          n.st   = ST_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s <= RST_STATE;
    end else begin
      s <= n;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign wb_dat_o                = s.dat;
  assign wb_ack_o                = s.ack;
  assign lnk.lclk                = s.lclk;
  assign lnk.ce_n                = s.ce_n;
  assign lnk.oe_n                = s.oe_n;
  assign lnk.we_n                = s.we_n;
  assign lnk.addr_valid_strobe_n = s.avs_n;
  assign lnk.host_dq             = s.dq;
  assign lnk.host_dq_oe          = s.dq_oe;

endmodule
`default_nettype wire

/* sim/amux_properties.sv */
// concurrent checks on the pins between the two ends
`timescale 1ns/1ps
`default_nettype none
module amux_properties (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // link pins
  input wire logic lclk,
  input wire logic ce_n,
  input wire logic oe_n,
  input wire logic we_n,
  input wire logic addr_valid_strobe_n,
  input wire logic host_dq_oe,
  input wire logic dev_dq_oe,
  input wire logic stall_oe
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_stall_with_data: assert property (stall_oe == dev_dq_oe)
    else $error("stall drive differs from data drive");
  a_release_on_ce: assert property (ce_n [*5] |-> !dev_dq_oe)
    else $error("device drives data while deselected");
  a_no_contention: assert property (!(dev_dq_oe && host_dq_oe))
    else $error("both ends drive the data lines");
  a_write_under_ce: assert property ($rose(we_n) |-> !ce_n)
    else $error("write completed without chip enable");
  a_wdata_held: assert property (!we_n |-> host_dq_oe)
    else $error("write data not driven while write enable low");
  a_oe_we_apart: assert property (!(!oe_n && !we_n))
    else $error("output enable and write enable both low");
  a_strobe_under_ce: assert property (!addr_valid_strobe_n |-> !ce_n)
    else $error("strobe low without chip enable");
  a_strobe_bounded: assert property (
    $fell(addr_valid_strobe_n) |-> ##[1:40] addr_valid_strobe_n)
    else $error("strobe held low too long");
  a_lclk_steps: assert property ($changed(lclk) |=> $stable(lclk) [*3])
    else $error("link clock half period too short");
  c_dev_drives: cover property ($rose(dev_dq_oe));
  c_write_done: cover property ($rose(we_n));
  c_link_clock: cover property ($rose(lclk));
endmodule
`default_nettype wire

/* sim/testbench.sv */
// self-checking bench joining host controller and device port
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic        clk_i;
  logic        rst_i;
  logic        cyc;
  logic        stb;
  logic        we;
  logic [7:0]  adr;
  logic [31:0] wdat;
  logic [31:0] rdat;
  logic        ack;
  logic        mode_en;
  logic        async_mode;
  logic        pol;
  logic        early;
  logic [3:0]  lat;
  logic [25:0] arr_addr;
  logic [25:0] wr_addr;
  logic [15:0] wr_data;
  logic        split_mode;
  logic        rd_pulse;
  logic        wr_pulse;
  logic [31:0] q;
  logic [31:0] stat;
  int          err_total;
  int          comparisons;
  int          rd_seen;
  int          wr_seen;

  // array contents derived from the address
  function automatic logic [15:0] arr_word(input logic [25:0] a);
    return a[15:0] ^ {6'h0, a[25:16]};
  endfunction

  amux_link_if lnk ();
  amux_host i_amux_host (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(wdat),
    .wb_sel_i(4'hF), .wb_dat_o(rdat), .wb_ack_o(ack), .lnk(lnk.host));
  amux_dev i_amux_dev (.clk_i(clk_i), .rst_i(rst_i), .lnk(lnk.dev),
    .mode_en_i(mode_en), .async_mode_i(async_mode), .stall_pol_i(pol),
    .stall_early_i(early), .latency_i(lat), .arr_addr_o(arr_addr),
    .arr_rd_o(rd_pulse), .arr_data_i(arr_word(arr_addr)), .wr_o(wr_pulse),
    .wr_addr_o(wr_addr), .wr_data_o(wr_data), .split_mode_o(split_mode));
  amux_properties i_amux_properties (.clk_i(clk_i), .rst_i(rst_i),
    .lclk(lnk.lclk), .ce_n(lnk.ce_n), .oe_n(lnk.oe_n), .we_n(lnk.we_n),
    .addr_valid_strobe_n(lnk.addr_valid_strobe_n),
    .host_dq_oe(lnk.host_dq_oe), .dev_dq_oe(lnk.dev_dq_oe),
    .stall_oe(lnk.stall_oe));

  // pulses seen on the array side
  always_ff @(posedge clk_i) begin
    rd_seen <= rd_seen + int'(rd_pulse);
    wr_seen <= wr_seen + int'(wr_pulse);
  end

  initial begin
    clk_i = 1'h0;
    forever #25 clk_i = ~clk_i;
  end

  task automatic test_done();
    $display("comparisons %0d errors %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] e,
      input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      err_total++;
      $display("Error %s expected %h seen %h", name, e, g);
    end
  endtask

  // one classic wishbone cycle, read data lands in q
  task automatic bus(input logic w, input logic [7:0] a,
      input logic [31:0] d);
    @(posedge clk_i);
    cyc  <= 1'h1;
    stb  <= 1'h1;
    we   <= w;
    adr  <= a;
    wdat <= d;
    do @(posedge clk_i); while (ack !== 1'h1);
    q = rdat;
    cyc <= 1'h0;
    stb <= 1'h0;
  endtask

  function automatic logic [31:0] ctl(input logic [1:0] op,
      input logic two, input logic keep, input logic [7:0] len);
    return {16'h0, len, 1'h0, early, pol, keep, two, op, 1'h1};
  endfunction

  // start one transfer, wait for done, clear it, fetch last word
  task automatic run(input logic [31:0] c, input logic [25:0] a);
    bus(1'h1, amux_pkg::REG_ADDR, {6'h0, a});
    bus(1'h1, amux_pkg::REG_CTRL, c);
    do bus(1'h0, amux_pkg::REG_STAT, 32'h0); while (q[1] !== 1'h1);
    stat = q;
    bus(1'h1, amux_pkg::REG_STAT, 32'h2);
    bus(1'h0, amux_pkg::REG_RDATA, 32'h0);
  endtask

  initial begin
    #2000000;
    err_total++;
    test_done();
  end

  initial begin
    rst_i = 1'h1;
    cyc = 1'h0;
    stb = 1'h0;
    we = 1'h0;
    adr = 8'h0;
    wdat = 32'h0;
    mode_en = 1'h0;
    async_mode = 1'h1;
    pol = 1'h0;
    early = 1'h0;
    lat = 4'h2;
    err_total = 0;
    comparisons = 0;
    repeat (16) @(posedge clk_i);
    rst_i <= 1'h0;
    mode_en <= 1'h1;
    repeat (4) @(posedge clk_i);
    chk("split mode", 32'h1, split_mode);
    bus(1'h1, amux_pkg::REG_WDATA, 32'hA5C3);
    run(ctl(amux_pkg::OP_AWR, 1'h1, 1'h0, 8'h1), 26'h2A51234);
    chk("write address", 26'h2A51234, wr_addr);
    chk("write data", 16'hA5C3, wr_data);
    chk("write pulses", 32'h1, wr_seen);
    run(ctl(amux_pkg::OP_ARD, 1'h1, 1'h0, 8'h1), 26'h1C5ABCD);
    chk("read two phases", arr_word(26'h1C5ABCD), q);
    chk("sense starts", 32'h2, rd_seen);
    run(ctl(amux_pkg::OP_ARD, 1'h0, 1'h0, 8'h1), 26'h3FF0777);
    chk("stored upper", arr_word(26'h1C50777), q);
    mode_en <= 1'h0;
    repeat (4) @(posedge clk_i);
    mode_en <= 1'h1;
    repeat (4) @(posedge clk_i);
    run(ctl(amux_pkg::OP_ARD, 1'h0, 1'h0, 8'h1), 26'h3FF0777);
    chk("upper cleared", arr_word(26'h0000777), q);
    async_mode <= 1'h0;
    for (int i = 0; i < 4; i++) begin
      pol   <= i[0];
      early <= i[1];
      lat   <= 4'(i + 1);
      @(posedge clk_i);
      run(ctl(amux_pkg::OP_SRD, 1'h1, i[0], 8'h4),
          {10'(i + 5), 16'h000E});
      chk("burst word", arr_word({10'(i + 5), 16'h0011}), q);
      chk("burst count", 32'h4, stat[15:8]);
    end
    run(ctl(amux_pkg::OP_SRD, 1'h0, 1'h0, 8'h2), 26'h3FF0020);
    chk("burst upper", arr_word({10'h8, 16'h0021}), q);
    chk("sense total", 32'h9, rd_seen);
    chk("write total", 32'h1, wr_seen);
    test_done();
  end
endmodule
`default_nettype wire
